// ### crc_gen_pkg.sv
// constants, types and helpers shared by the crc generator
// What this block does
// [RL1] polynomial length comes from a five-bit field holding length minus one
// [RL2] set tap bits 1..31 add an xor; the zero-order term always applies
// [RL3] at length 32 the top term applies implicitly without a tap bit
// [RL4] word width 1..32 bits set by a five-bit field holding width minus one
// [RL5] fifo depth is 4, 8 or 16 words depending on the width field
// [RL6] writes are byte wide; unused upper bits of narrow words are ignored
// [RL7] word count rises when the byte holding the word's top bit is written
// [RL8] software writes the low data half before the high half
// [RL9] shifting runs only while run is set and words are waiting; here a word already loaded finishes shifting after run clears
// [RL10] a word moves to the shift buffer, count drops, two bits per cycle
// [RL11] full flag when count equals depth, empty flag when count is zero
// [RL12] disabling empties the fifo and resets engine, result and high data
// [RL13] software waits one cycle after a result write before reading count
// [RL14] lsb-first select picks input bit order; result stays non-reflected
// [RL15] with select at zero, interrupt when count goes from one to zero
// [RL16] with select at one, interrupt on hardware run clear, not on software
// [RL17] result final at most (length field + 1)/2 cycles after the interrupt; the engine here takes about (width field + 1)/2
// [RL18] run clears by itself when the calculation finishes
// [RL19] software configures, preloads, clears result, runs, refills, reads
// [RL20] idle halt set stops the block while the processor idles
// [RL21] engine is a length-bit shift register with feedback into taps
package crc_gen_pkg;

  // register byte offsets on the bus
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_CFG  = 6'h04;
  localparam logic [5:0] OFS_TAPL = 6'h08;
  localparam logic [5:0] OFS_TAPH = 6'h0C;
  localparam logic [5:0] OFS_DATL = 6'h10;
  localparam logic [5:0] OFS_DATH = 6'h14;
  localparam logic [5:0] OFS_RESL = 6'h18;
  localparam logic [5:0] OFS_RESH = 6'h1C;

  // control_status_reg field positions
  localparam int CTL_ON    = 15;
  localparam int CTL_IDLE  = 13;
  localparam int CTL_CNT   = 8;
  localparam int CTL_FULL  = 7;
  localparam int CTL_EMPTY = 6;
  localparam int CTL_ISEL  = 5;
  localparam int CTL_RUN   = 4;
  localparam int CTL_LSBF  = 3;
  // width_length_reg field positions
  localparam int CFG_WIDTH = 8;
  localparam int CFG_PLEN  = 0;

  // depth selection
  localparam logic [4:0] WIDE_MIN   = 5'h10;
  localparam logic [4:0] MID_MIN    = 5'h08;
  localparam logic [4:0] DEPTH_WIDE = 5'h04;
  localparam logic [4:0] DEPTH_MID  = 5'h08;
  localparam logic [4:0] DEPTH_NARR = 5'h10;
  localparam int         FIFO_MAX   = 16;

  // configuration carried as one bundle
  typedef struct packed {
    logic       onBit;
    logic       idleHalt;
    logic       isel;
    logic       lsbFirst;
    logic [4:0] width;
    logic [4:0] plen;
  } cfg_t;

  localparam cfg_t CFG_RST = '0;

  typedef enum logic [0:0] {
    ENG_IDLE  = 1'b0,
    ENG_SHIFT = 1'b1
  } eng_state_t;

  // fifo depth for a width field
  function automatic logic [4:0] depthOf(input logic [4:0] w);
    if (w >= WIDE_MIN) begin
      return DEPTH_WIDE;
    end else if (w >= MID_MIN) begin
      return DEPTH_MID;
    end
    return DEPTH_NARR;
  endfunction : depthOf

  // ones in the low n+1 bits
  function automatic logic [31:0] lowMask(input logic [4:0] n);
    return 32'hFFFF_FFFF >> (5'h1F - n);
  endfunction : lowMask

endpackage : crc_gen_pkg

// ### crc_shift_step.sv
// combinational crc engine step, one or two input bits
`timescale 1ns/1ps
`default_nettype none
module crc_shift_step
  import crc_gen_pkg::*;
(
  input  wire logic [31:0] crcIn,
  input  wire logic [31:0] taps,
  input  wire logic [4:0]  plen,
  input  wire logic        bitA,
  input  wire logic        bitB,
  input  wire logic        twoBits,
  output logic      [31:0] crcOut
);

  // one shift: feedback xors into enabled taps and term zero
  function automatic logic [31:0] step(input logic [31:0] c, input logic d,
                                       input logic [31:0] t,
                                       input logic [4:0] p);
    logic        fb;
    logic [31:0] poly;
    fb   = d ^ c[p];                          // RL21
    poly = {t[31:1], 1'b1} & lowMask(p);      // RL2
    c    = (c << 1) & lowMask(p);             // RL1 RL3
    if (fb) begin
      c = c ^ poly;                           // RL21
    end
    return c;
  endfunction : step

  // first bit always, second when two are due
  always_comb begin
    crcOut = step(crcIn, bitA, taps, plen);
    if (twoBits) begin
      crcOut = step(crcOut, bitB, taps, plen);
    end
  end

endmodule : crc_shift_step
`default_nettype wire

// ### programmable_crc_generator.sv
// programmable crc generator with avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
module programmable_crc_generator
  import crc_gen_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        cpuIdle,
  output logic             crcIrq
);

  logic             rstMeta_q;
  logic             rstN;
  logic             waitReq_q;
  logic [31:0]      rdData_q;
  cfg_t             cfg_q;
  logic             run_q;
  logic [15:1]      tapLow_q;
  logic [15:0]      tapHigh_q;
  logic [15:0]      dataLow_q;
  logic [15:0]      dataHigh_q;
  logic [31:0]      result_q;
  logic [31:0]      fifoMem [FIFO_MAX];
  logic [3:0]       wrPtr_q;
  logic [3:0]       rdPtr_q;
  logic [4:0]       count_q;
  logic [4:0]       count_d;
  logic [31:0]      buf_q;
  logic [5:0]       bitsLeft_q;
  eng_state_t       engSt_q;
  logic             irq_q;
  logic             wrEn;
  logic [4:0]       depth;
  logic [3:0]       ptrMask;
  logic [15:0]      lowNew;
  logic [15:0]      highNew;
  logic [1:0]       topIdx;
  logic             commit;
  logic             active;
  logic             shiftNow;
  logic             lastBits;
  logic             load;
  logic             hwDone;
  logic             swRunWr;
  logic             irqEvt;
  logic             bitA;
  logic             bitB;
  logic [31:0]      engOut;
  logic [31:0]      readMux;

  // merge a 16-bit register with two byte lanes
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0]  be);
    return {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction : merge16

  // reset release through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_q <= 1'b0;
      rstN      <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN      <= rstMeta_q;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstN);

  // bus handshake: one wait cycle, action at the edge waitrequest is low
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      waitReq_q <= 1'b1;
    end else begin
      waitReq_q <= ~((avs_read | avs_write) & waitReq_q);
    end
  end

  a_bus_one_wait: assert property ((avs_read | avs_write) && waitReq_q
    |=> !waitReq_q ##1 waitReq_q)
    else $error("bus answer not after one wait cycle");

  assign wrEn    = avs_write & ~waitReq_q;
  assign swRunWr = wrEn & (avs_address == OFS_CTRL) & avs_byteenable[0];

  // configuration derived values
  assign depth   = depthOf(cfg_q.width);                  // RL5
  assign ptrMask = depth[3:0] - 4'h1;
  assign topIdx  = cfg_q.width[4:3];                      // RL4

  // new data halves as they stand after this write
  assign lowNew  = (wrEn && avs_address == OFS_DATL)
                 ? merge16(dataLow_q, avs_writedata[15:0], avs_byteenable[1:0])
                 : dataLow_q;
  assign highNew = (wrEn && avs_address == OFS_DATH)
                 ? merge16(dataHigh_q, avs_writedata[15:0], avs_byteenable[1:0])
                 : dataHigh_q;

  // word commits when the lane holding its top bit is written
  assign commit = wrEn & cfg_q.onBit & (count_q != depth)          // RL11
                & avs_byteenable[topIdx[0]]                        // RL7
                & ((avs_address == OFS_DATL & ~topIdx[1])
                 | (avs_address == OFS_DATH & topIdx[1]));         // RL8

  // engine control terms
  assign active   = cfg_q.onBit & ~(cfg_q.idleHalt & cpuIdle);    // RL20
  assign shiftNow = active & (engSt_q == ENG_SHIFT);
  assign lastBits = shiftNow & (bitsLeft_q <= 6'h02);
  assign load     = active & run_q & (count_q != 5'h00)           // RL9
                  & ((engSt_q == ENG_IDLE) | lastBits);
  assign hwDone   = run_q & lastBits & (count_q == 5'h00);

  // pick the next input bits by direction
  always_comb begin
    if (cfg_q.lsbFirst) begin
      bitA = buf_q[0];                                    // RL14
      bitB = buf_q[1];
    end else begin
      bitA = buf_q[cfg_q.width];                          // RL14
      bitB = buf_q[cfg_q.width - 5'h01];
    end
  end

  crc_shift_step i_crc_shift_step (
    .crcIn   (result_q),
    .taps    ({tapHigh_q, tapLow_q, 1'b1}),
    .plen    (cfg_q.plen),
    .bitA    (bitA),
    .bitB    (bitB),
    .twoBits (bitsLeft_q >= 6'h02),
    .crcOut  (engOut)
  );

  // configuration registers survive a disable
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cfg_q     <= CFG_RST;
      tapLow_q  <= '0;
      tapHigh_q <= 16'h0000;
    end else if (wrEn) begin
      case (avs_address)
        OFS_CTRL: begin
          if (avs_byteenable[1]) begin
            cfg_q.onBit    <= avs_writedata[CTL_ON];
            cfg_q.idleHalt <= avs_writedata[CTL_IDLE];
          end
          if (avs_byteenable[0]) begin
            cfg_q.isel     <= avs_writedata[CTL_ISEL];
            cfg_q.lsbFirst <= avs_writedata[CTL_LSBF];
          end
        end
        OFS_CFG: begin
          if (avs_byteenable[1]) begin
            cfg_q.width <= avs_writedata[CFG_WIDTH +: 5];      // RL4
          end
          if (avs_byteenable[0]) begin
            cfg_q.plen <= avs_writedata[CFG_PLEN +: 5];        // RL1
          end
        end
        OFS_TAPL: begin
          if (avs_byteenable[1]) begin
            tapLow_q[15:8] <= avs_writedata[15:8];
          end
          if (avs_byteenable[0]) begin
            tapLow_q[7:1] <= avs_writedata[7:1];               // RL2
          end
        end
        OFS_TAPH: begin
          tapHigh_q <= merge16(tapHigh_q, avs_writedata[15:0],
                               avs_byteenable[1:0]);
        end
        default: begin
        end
      endcase
    end
  end

  // data input halves; high half cleared while disabled
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      dataLow_q  <= 16'h0000;
      dataHigh_q <= 16'h0000;
    end else begin
      dataLow_q <= lowNew;
      if (!cfg_q.onBit) begin
        dataHigh_q <= 16'h0000;                           // RL12
      end else begin
        dataHigh_q <= highNew;
      end
    end
  end

  // fifo storage, unused upper bits dropped on entry
  always_ff @(posedge clk) begin
    if (commit) begin
      fifoMem[wrPtr_q] <= {highNew, lowNew} & lowMask(cfg_q.width); // RL6
    end
  end

  // fifo pointers and word count
  always_comb begin
    count_d = count_q;
    if (commit) begin
      count_d = count_d + 5'h01;                          // RL7
    end
    if (load) begin
      count_d = count_d - 5'h01;                          // RL10
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr_q <= 4'h0;
      rdPtr_q <= 4'h0;
      count_q <= 5'h00;
    end else if (!cfg_q.onBit) begin
      wrPtr_q <= 4'h0;                                    // RL12
      rdPtr_q <= 4'h0;
      count_q <= 5'h00;
    end else begin
      count_q <= count_d;
      if (commit) begin
        wrPtr_q <= (wrPtr_q + 4'h1) & ptrMask;
      end
      if (load) begin
        rdPtr_q <= (rdPtr_q + 4'h1) & ptrMask;
      end
    end
  end

  a_count_inc: assert property (commit && !load |=> count_q == $past(count_q) + 5'h01) // RL7
    else $error("committed word not counted");
  a_full_blocks: assert property (count_q == depth && !load && cfg_q.onBit // RL11
    |=> count_q == $past(count_q))
    else $error("count moved past full");
  a_disable_clear: assert property (!cfg_q.onBit |=> count_q == 5'h00 && !run_q // RL12
    && engSt_q == ENG_IDLE && result_q == 32'h0000_0000)
    else $error("disable did not clear state");

  // shift buffer and engine state
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      buf_q      <= 32'h0000_0000;
      bitsLeft_q <= 6'h00;
      engSt_q    <= ENG_IDLE;
    end else if (!cfg_q.onBit) begin
      buf_q      <= 32'h0000_0000;                        // RL12
      bitsLeft_q <= 6'h00;
      engSt_q    <= ENG_IDLE;
    end else begin
      case (engSt_q)
        ENG_IDLE: begin
          if (load) begin
            buf_q      <= fifoMem[rdPtr_q];               // RL10
            bitsLeft_q <= {1'b0, cfg_q.width} + 6'h01;
            engSt_q    <= ENG_SHIFT;
          end
        end
        ENG_SHIFT: begin
          if (load) begin
            buf_q      <= fifoMem[rdPtr_q];               // RL10
            bitsLeft_q <= {1'b0, cfg_q.width} + 6'h01;
          end else if (lastBits) begin
            bitsLeft_q <= 6'h00;
            engSt_q    <= ENG_IDLE;
          end else if (shiftNow) begin
            bitsLeft_q <= bitsLeft_q - 6'h02;             // RL10
            buf_q <= cfg_q.lsbFirst ? (buf_q >> 2) : (buf_q << 2); // RL14
          end
        end
        default: begin
          engSt_q <= ENG_IDLE;
        end
      endcase
    end
  end

  a_load_width: assert property (load |=> bitsLeft_q == {1'b0, cfg_q.width} + 6'h01) // RL10
    else $error("buffer not loaded with word width");
  a_two_per_cycle: assert property (shiftNow && bitsLeft_q > 6'h02 && !load // RL10
    && cfg_q.onBit |=> bitsLeft_q == $past(bitsLeft_q) - 6'h02)
    else $error("engine not shifting two bits");
  a_run_gate: assert property (engSt_q == ENG_IDLE && (!run_q || count_q == 5'h00) // RL9
    |=> engSt_q == ENG_IDLE)
    else $error("engine started without run and data");
  a_idle_halt: assert property (cfg_q.onBit && cfg_q.idleHalt && cpuIdle // RL20
    && engSt_q == ENG_SHIFT ##1 cfg_q.onBit |-> $stable(bitsLeft_q) && $stable(result_q))
    else $error("engine moved while idle halted");

  // run bit: software write wins, hardware clears on completion
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      run_q <= 1'b0;
    end else if (!cfg_q.onBit) begin
      run_q <= 1'b0;                                      // RL12
    end else if (swRunWr) begin
      run_q <= avs_writedata[CTL_RUN];
    end else if (hwDone) begin
      run_q <= 1'b0;                                      // RL18
    end
  end

  a_auto_clear: assert property (hwDone && !swRunWr && cfg_q.onBit |=> !run_q) // RL18
    else $error("run not cleared at completion");

  // running crc; result is final when run clears, (width field + 1)/2 cycles rounded up after the last load; the allowed bound is (length field + 1)/2
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      result_q <= 32'h0000_0000;
    end else if (!cfg_q.onBit) begin
      result_q <= 32'h0000_0000;                          // RL12
    end else if (wrEn && avs_address == OFS_RESL) begin
      result_q[15:0] <= merge16(result_q[15:0], avs_writedata[15:0],
                                avs_byteenable[1:0]);
    end else if (wrEn && avs_address == OFS_RESH) begin
      result_q[31:16] <= merge16(result_q[31:16], avs_writedata[15:0],
                                 avs_byteenable[1:0]);
    end else if (shiftNow) begin
      result_q <= engOut;                                 // RL21 RL17
    end
  end

  // interrupt events
  assign irqEvt = (~cfg_q.isel & load & ~commit & (count_q == 5'h01))  // RL15
                | (cfg_q.isel & hwDone & ~swRunWr);                    // RL16

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irqEvt & cfg_q.onBit;
    end
  end

  a_irq_count: assert property (!cfg_q.isel && cfg_q.onBit && count_q == 5'h01 // RL15
    && count_d == 5'h00 |=> irq_q)
    else $error("no interrupt on count one to zero");
  a_irq_swstop: assert property (cfg_q.isel && swRunWr // RL16
    && !avs_writedata[CTL_RUN] |=> !irq_q)
    else $error("software stop raised interrupt");
  a_irq_done: assert property (cfg_q.isel && $fell(run_q) && !$past(swRunWr) // RL16
    && $past(cfg_q.onBit) |-> irq_q)
    else $error("no interrupt on hardware run clear");

  // read mux; flags derived from the live count
  always_comb begin
    readMux = 32'h0000_0000;
    case (avs_address)
      OFS_CTRL: begin
        readMux[CTL_ON]         = cfg_q.onBit;
        readMux[CTL_IDLE]       = cfg_q.idleHalt;
        readMux[CTL_CNT +: 5]   = count_q;
        readMux[CTL_FULL]       = (count_q == depth);        // RL11
        readMux[CTL_EMPTY]      = (count_q == 5'h00);        // RL11
        readMux[CTL_ISEL]       = cfg_q.isel;
        readMux[CTL_RUN]        = run_q;
        readMux[CTL_LSBF]       = cfg_q.lsbFirst;
      end
      OFS_CFG: begin
        readMux[CFG_WIDTH +: 5] = cfg_q.width;
        readMux[CFG_PLEN +: 5]  = cfg_q.plen;
      end
      OFS_TAPL: readMux[15:0] = {tapLow_q, 1'b0};            // RL2
      OFS_TAPH: readMux[15:0] = tapHigh_q;
      OFS_DATL: readMux[15:0] = dataLow_q;
      OFS_DATH: readMux[15:0] = dataHigh_q;
      OFS_RESL: readMux[15:0] = result_q[15:0];
      OFS_RESH: readMux[15:0] = result_q[31:16];
      default:  readMux = 32'h0000_0000;
    endcase
  end

  // read data captured in the wait cycle, held until the next read
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rdData_q <= 32'h0000_0000;
    end else if (avs_read && waitReq_q) begin
      rdData_q <= readMux;
    end
  end

  assign avs_readdata    = rdData_q;
  assign avs_waitrequest = waitReq_q;
  assign crcIrq          = irq_q;

endmodule : programmable_crc_generator
`default_nettype wire

// ### programmable_crc_generator_tb.sv
// self-checking testbench of the programmable crc generator
`timescale 1ns/1ps
`default_nettype none
module programmable_crc_generator_tb
  import crc_gen_pkg::*;
;
  logic        clk;
  logic        nrst;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        cpuIdle;
  logic        crcIrq;
  logic [31:0] words [8];
  int          irqSeen     = 0;
  int          miscompares = 0;
  int          cmpCount    = 0;

  programmable_crc_generator i_programmable_crc_generator (
    .clk             (clk),
    .nrst            (nrst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .cpuIdle         (cpuIdle),
    .crcIrq          (crcIrq)
  );

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // count interrupt pulses
  always @(posedge clk) begin
    if (crcIrq === 1'b1) begin
      irqSeen <= irqSeen + 1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    if (miscompares == 0 && cmpCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // one write, held until waitrequest is seen low
  task automatic busWrite(input logic [5:0] a, input logic [15:0] d, input logic [1:0] be);
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= {16'h0000, d};
    avs_byteenable <= {2'b00, be};
    avs_write      <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : busWrite

  // one read, data taken at the completing edge
  task automatic busRead(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : busRead

  // write one data word, top byte last
  task automatic pushWord(input logic [4:0] w, input logic [31:0] d);
    if (w >= 5'h10) begin
      busWrite(OFS_DATL, d[15:0], 2'b11);
      busWrite(OFS_DATH, d[31:16], (w >= 5'h18) ? 2'b11 : 2'b01);
    end else begin
      busWrite(OFS_DATL, d[15:0], (w >= 5'h08) ? 2'b11 : 2'b01);
    end
  endtask : pushWord

  // bitwise reference of one word through the engine
  function automatic logic [31:0] crcStep(input logic [31:0] c, input logic [31:0] t,
                                          input logic [4:0] p, input logic [4:0] w,
                                          input logic lsb, input logic [31:0] d);
    logic [31:0] m;
    logic        fb;
    int          k;
    m = 32'hFFFF_FFFF >> (31 - p);
    for (int i = 0; i < 32; i++) begin
      if (i <= w) begin
        k = lsb ? i : w - i;
        fb = d[k] ^ c[p];
        c = (c << 1) & m;
        if (fb) begin
          c = c ^ ((t | 32'h0000_0001) & m);
        end
      end
    end
    return c;
  endfunction : crcStep

  // reset values, read-only bits and unmapped space
  task automatic testRegs;
    logic [31:0] r;
    busRead(OFS_CTRL, r);
    check(r, 32'h0000_0040);
    busWrite(OFS_CTRL, 16'h1FC0, 2'b11);
    busRead(OFS_CTRL, r);
    check(r, 32'h0000_0040);
    busWrite(OFS_CFG, 16'hFFFF, 2'b11);
    busRead(OFS_CFG, r);
    check(r, 32'h0000_1F1F);
    busWrite(OFS_TAPL, 16'hFFFF, 2'b11);
    busRead(OFS_TAPL, r);
    check(r, 32'h0000_FFFE);
    busWrite(OFS_TAPH, 16'hFFFF, 2'b11);
    busRead(OFS_TAPH, r);
    check(r, 32'h0000_FFFF);
    busWrite(6'h24, 16'h5A5A, 2'b11);
    busRead(6'h24, r);
    check(r, 32'h0000_0000);
  endtask : testRegs

  // fill the fifo at each depth, overflow, then disable
  task automatic testDepth;
    logic [31:0] r;
    logic [4:0]  wv;
    logic [15:0] dp;
    for (int i = 0; i < 3; i++) begin
      wv = 5'h1F >> i;
      dp = 16'h0004 << i;
      busWrite(OFS_CTRL, 16'h0000, 2'b11);
      busWrite(OFS_CFG, {3'b000, wv, 8'h00}, 2'b11);
      busWrite(OFS_CTRL, 16'h8000, 2'b11);
      if (i == 0) begin
        busWrite(OFS_DATL, 16'h1234, 2'b11);
        busRead(OFS_CTRL, r);
        check(r, 32'h0000_8040);
      end
      for (int j = 0; j < dp; j++) begin
        pushWord(wv, 32'hA5A5_0000 + j);
      end
      busRead(OFS_CTRL, r);
      check(r, {16'h0000, 16'h8080 | (dp << 8)});
      pushWord(wv, 32'hFFFF_FFFF);
      busRead(OFS_CTRL, r);
      check(r, {16'h0000, 16'h8080 | (dp << 8)});
      busWrite(OFS_CTRL, 16'h0000, 2'b11);
      busRead(OFS_CTRL, r);
      check(r, 32'h0000_0040);
    end
  endtask : testDepth

  // full calculation against the reference
  task automatic runCrc(input logic [31:0] taps, input logic [4:0] p, input logic [4:0] w,
                        input logic lsb, input logic isel, input logic idle, input int n);
    logic [31:0] r;
    logic [31:0] exp;
    logic [15:0] ctl;
    int          base;
    int          k;
    ctl = {1'b1, 1'b0, idle, 7'h00, isel, 1'b0, lsb, 3'b000};
    busWrite(OFS_CTRL, 16'h0000, 2'b11);
    busWrite(OFS_CFG, {3'b000, w, 3'b000, p}, 2'b11);
    busWrite(OFS_TAPL, taps[15:0], 2'b11);
    busWrite(OFS_TAPH, taps[31:16], 2'b11);
    busWrite(OFS_CTRL, ctl, 2'b11);
    exp = 32'h0000_0000;
    for (k = 0; k < n; k++) begin
      pushWord(w, words[k]);
      exp = crcStep(exp, taps, p, w, lsb, words[k]);
    end
    busWrite(OFS_RESL, 16'h0000, 2'b11);
    busWrite(OFS_RESH, 16'h0000, 2'b11);
    if (idle) begin
      @(posedge clk);
      cpuIdle <= 1'b1;
    end
    base = irqSeen;
    busWrite(OFS_CTRL, ctl | 16'h0010, 2'b11);
    if (idle) begin
      repeat (20) @(posedge clk);
      busRead(OFS_CTRL, r);
      check({26'h0, r[12:8], r[4]}, {26'h0, n[4:0], 1'b1});
      cpuIdle <= 1'b0;
      // pause the engine again in mid-word; the result must not suffer
      repeat (3) @(posedge clk);
      cpuIdle <= 1'b1;
      repeat (4) @(posedge clk);
      cpuIdle <= 1'b0;
    end
    k = 0;
    do begin
      busRead(OFS_CTRL, r);
      k++;
    end while (r[4] !== 1'b0 && k < 100);
    check({31'h0, r[4]}, 32'h0000_0000);
    repeat (3) @(posedge clk);
    check(32'(irqSeen - base), 32'h0000_0001);
    busRead(OFS_RESL, r);
    check(r, {16'h0000, exp[15:0]});
    busRead(OFS_RESH, r);
    check(r, {16'h0000, exp[31:16]});
  endtask : runCrc

  // software stop gives no interrupt; disable clears the result
  task automatic testSwStop;
    logic [31:0] r;
    int          base;
    busWrite(OFS_CTRL, 16'h0000, 2'b11);
    busWrite(OFS_CFG, 16'h1F1F, 2'b11);
    busWrite(OFS_CTRL, 16'h8020, 2'b11);
    pushWord(5'h1F, 32'hDEAD_BEEF);
    pushWord(5'h1F, 32'h1357_9BDF);
    base = irqSeen;
    busWrite(OFS_CTRL, 16'h8030, 2'b11);
    busWrite(OFS_CTRL, 16'h8020, 2'b11);
    repeat (40) @(posedge clk);
    busRead(OFS_CTRL, r);
    check({31'h0, r[4]}, 32'h0000_0000);
    check(32'(irqSeen - base), 32'h0000_0000);
    busWrite(OFS_CTRL, 16'h0000, 2'b11);
    busRead(OFS_RESL, r);
    check(r, 32'h0000_0000);
    busRead(OFS_RESH, r);
    check(r, 32'h0000_0000);
  endtask : testSwStop

  // main sequence
  initial begin
    nrst           = 1'b0;
    avs_address    = 6'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'h0;
    cpuIdle        = 1'b0;
    for (int k = 0; k < 8; k++) begin
      words[k] = 32'h9E37_79B9 * (k + 1);
    end
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    testRegs();
    testDepth();
    runCrc(32'h0000_1021, 5'h0F, 5'h07, 1'b0, 1'b1, 1'b1, 4);
    runCrc(32'h04C1_1DB7, 5'h1F, 5'h1F, 1'b0, 1'b0, 1'b0, 3);
    runCrc(32'h0000_0007, 5'h07, 5'h04, 1'b1, 1'b1, 1'b0, 5);
    testSwStop();
    stop_test();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    stop_test();
  end

endmodule : programmable_crc_generator_tb
`default_nettype wire
